// File: src/flash_seq_params.svh
/*
  constants for the flash command sequencer: command codes, status bit
  positions, key window, banked window and execution lengths.
  assumes it is included by bare name from the package and the modules.
*/
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH

// command codes
`define CMD_VERIFY 8'h05
`define CMD_PROG 8'h20
`define CMD_SECT 8'h40
`define CMD_MASS 8'h41

// status write data bit positions
`define STAT_BUF_EMPTY 7
`define STAT_CMD_DONE 6
`define STAT_PROT_ERR 5
`define STAT_ACC_ERR 4
`define STAT_BLANK 2

// sector of 256 words: byte address bits [8:0] ignored
`define SECT_MASK 16'hFE00
// banked page window
`define WIN_LO 16'h8000
`define WIN_HI 16'hBFFF
// backdoor key words start here, four words
`define KEY_BASE 16'hFF00
`define UNSECURED_CODE 2'h2

// execution lengths in timing clock ticks
`define TICKS_VERIFY 12'h040
`define TICKS_PROG 12'h008
`define TICKS_SECT 12'h3E8
`define TICKS_MASS 12'hFA0
`define DIV_W 7

`endif

// File: src/flash_seq_pkg.sv
/*
  types shared by the sequencer and its timing divider.
  assumes the params header is on the include path.
*/
`default_nettype none
`include "flash_seq_params.svh"

package flash_seq_pkg;

  // gray along empty -> word -> command -> queued
  typedef enum logic [1:0] {
    SEQ_EMPTY = 2'h0,
    SEQ_WORD = 2'h1,
    SEQ_CMD = 2'h3,
    SEQ_QUEUED = 2'h2
  } seq_t;

  typedef enum logic [2:0] {
    REG_CLKDIV = 3'h0,
    REG_SECURITY = 3'h1,
    REG_CONFIG = 3'h2,
    REG_PROTECT = 3'h3,
    REG_STATUS = 3'h4,
    REG_COMMAND = 3'h5,
    REG_OTHER = 3'h6
  } reg_sel_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [15:0] data;
  } cmd_entry_t;

  typedef struct packed {
    logic [`DIV_W-1:0] cnt;
    logic tick;
  } div_st_t;

  typedef struct packed {
    seq_t seq;
    cmd_entry_t buf_e;
    cmd_entry_t act;
    logic act_v;
    logic [11:0] tmr;
    logic acc_err;
    logic prot_err;
    logic buf_empty;
    logic cmd_done;
    logic blank;
    logic divld;
    logic [`DIV_W-1:0] div;
    logic [1:0] key_idx;
    logic key_ok;
    logic unsec;
    logic stop_seen;
    logic hv_on;
    logic op_start;
    logic irq;
    logic rd_invalid;
    logic prot_wr_en;
    logic [1:0] secure_lvl;
  } seq_st_t;

endpackage : flash_seq_pkg

`default_nettype wire

// File: src/flash_tick_div.sv
/*
  timing clock divider: one-cycle tick every div+1 bus clocks.
  assumes run stays low until the divider value has been loaded.
*/
`default_nettype none
`include "flash_seq_params.svh"

module flash_tick_div (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic [`DIV_W-1:0] div,
  // tick out
  output logic tick
);
  import flash_seq_pkg::*;

  div_st_t q, d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (run) begin
      if (q.cnt >= div) begin
        d.cnt = '0;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + `DIV_W'(1);
      end
    end else begin
      d.cnt = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule // flash_tick_div

`default_nettype wire

// File: src/flash_command_sequencer.sv
/*
  command state machine of a program/erase flash array: buffered sequence,
  access and protection checks, two-stage queue, stop handling, backdoor
  key and interrupt request.
  assumes the cpu side presents one write per cycle as a pulse, and that
  prot_hit reflects the address shown on buf_addr.
*/
//Contract
//- erase verify sets blank only if erased
//- program writes buffered word at buffered address
//- sector erase clears 256-word sector of address
//- mass erase needs all three protect-off bits
//- no divider or misaligned write: access error
//- banked write without our page: access error
//- array write with buffer busy: access error
//- second word or command: access error
//- wrong register write mid-sequence: access error
//- invalid command code: access error
//- secured nonsecure or debug non-mass: error
//- writing zero to buffer flag aborts, errors
//- reads never error; busy array reads invalid
//- error flags lock command launch
//- protected target or mass: protection violation
//- stop aborts, kills queue, sets flags
//- wait lets commands finish; interrupt wakes
//- debug: protect writable, secured only mass
//- four key words from key base unsecure
//- unlock leaves key, byte, protections; reset
//- reset aborts running command at once
//- interrupt on enabled empty or complete flag
//- writing one launches, clears complete flag
//- complete only when nothing active or queued
//- buffer plus active stage form queue
//- divider write sets loaded, gates commands
`default_nettype none
`include "flash_seq_params.svh"

module flash_command_sequencer (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // array write strobe
  input wire logic arr_wr,
  input wire logic [15:0] arr_addr,
  input wire logic [15:0] arr_wdata,
  input wire logic arr_byte,
  // register write strobe
  input wire logic reg_wr,
  input wire flash_seq_pkg::reg_sel_t reg_sel,
  input wire logic [7:0] reg_wdata,
  // configuration and protection levels
  input wire logic buffer_empty_irq_enable,
  input wire logic command_complete_irq_enable,
  input wire logic backdoor_enable,
  input wire logic backdoor_access_mode,
  input wire logic low_region_protect_disable,
  input wire logic high_region_protect_disable,
  input wire logic protection_open_select,
  input wire logic prot_hit,
  input wire logic page_hit,
  // chip modes and security source
  input wire logic stop_mode,
  input wire logic background_debug_mode,
  input wire logic special_single_chip,
  input wire logic nonsecure_src,
  input wire logic [1:0] security_byte,
  input wire logic [3:0][15:0] key_words,
  // array engine
  input wire logic blank_in,
  output logic op_start,
  output flash_seq_pkg::cmd_entry_t op,
  output logic hv_on,
  output logic [15:0] buf_addr,
  // status
  output logic access_error_flag,
  output logic protection_violation_flag,
  output logic buffer_empty_flag,
  output logic command_complete_flag,
  output logic blank_flag,
  output logic divider_loaded_flag,
  output logic read_invalid,
  output logic prot_wr_en,
  output logic [1:0] security_state_field,
  output logic irq
);
  import flash_seq_pkg::*;

  seq_st_t q, d;
  logic tick;

  flash_tick_div i_flash_tick_div (
    .mclk(mclk),
    .rst_b(rst_b),
    .run(q.divld),
    .div(q.div),
    .tick(tick)
  );

  function automatic logic [11:0] ticks_of(input logic [7:0] c);
    logic [11:0] t;
    t = `TICKS_PROG;
    if (c == `CMD_VERIFY) t = `TICKS_VERIFY;
    else if (c == `CMD_SECT) t = `TICKS_SECT;
    else if (c == `CMD_MASS) t = `TICKS_MASS;
    return t;
  endfunction

  function automatic logic valid_cmd(input logic [7:0] c);
    return (c == `CMD_VERIFY) || (c == `CMD_PROG) || (c == `CMD_SECT) ||
           (c == `CMD_MASS);
  endfunction

  always_comb begin
    logic err;
    logic pv;
    logic finish;
    logic keymode;
    logic secured;
    logic in_seq;
    err = 1'b0;
    pv = 1'b0;
    finish = q.act_v && tick && (q.tmr == 12'h000);
    keymode = backdoor_enable && backdoor_access_mode;
    secured = q.secure_lvl != `UNSECURED_CODE;
    in_seq = (q.seq == SEQ_WORD) || (q.seq == SEQ_CMD);
    d = q;
    d.op_start = 1'b0;

    // execution stage
    if (finish) begin
      if (q.act.cmd == `CMD_VERIFY) d.blank = blank_in;
      d.act_v = 1'b0;
      d.hv_on = 1'b0;
      if (q.seq != SEQ_QUEUED) d.cmd_done = 1'b1;
    end else if (q.act_v && tick) begin
      d.tmr = q.tmr - 12'h001;
    end

    // queued buffer moves into the active stage; high voltage stays on
    if (q.seq == SEQ_QUEUED && (!q.act_v || finish)) begin
      d.act = q.buf_e;
      if (q.buf_e.cmd == `CMD_SECT) d.act.addr = q.buf_e.addr & `SECT_MASK;
      if (q.buf_e.cmd == `CMD_VERIFY) d.blank = 1'b0;
      d.act_v = 1'b1;
      d.tmr = ticks_of(q.buf_e.cmd) - 12'h001;
      d.hv_on = 1'b1;
      d.op_start = 1'b1;
      d.seq = SEQ_EMPTY;
      d.buf_empty = 1'b1;
    end

    // key window reset when access mode drops
    if (!keymode) begin
      d.key_idx = 2'h0;
      d.key_ok = 1'b1;
    end

    if (arr_wr) begin
      if (keymode) begin
        // debug in special single chip may never unlock
        if (background_debug_mode && special_single_chip) begin
          d.key_ok = 1'b0;
        end else begin
          // key compare only; stored key, byte and protections untouched
          if (arr_addr != (`KEY_BASE | {13'h0, q.key_idx, 1'b0}) ||
              arr_wdata != key_words[q.key_idx]) begin
            d.key_ok = 1'b0;
          end
          d.key_idx = q.key_idx + 2'h1;
          if (q.key_idx == 2'h3 && d.key_ok) d.unsec = 1'b1;
        end
      end else if (!q.divld) begin
        err = 1'b1;
      end else if (arr_byte || arr_addr[0]) begin
        err = 1'b1;
      end else if (arr_addr >= `WIN_LO && arr_addr <= `WIN_HI && !page_hit) begin
        err = 1'b1;
      end else if (!q.buf_empty) begin
        err = 1'b1;
      end else if (q.seq != SEQ_EMPTY) begin
        err = 1'b1;
      end else begin
        d.buf_e.addr = arr_addr;
        d.buf_e.data = arr_wdata;
        d.seq = SEQ_WORD;
      end
    end

    if (reg_wr) begin
      if (reg_sel == REG_COMMAND) begin
        if (q.seq == SEQ_CMD) begin
          err = 1'b1;
        end else if (q.seq == SEQ_WORD) begin
          if (!valid_cmd(reg_wdata)) begin
            err = 1'b1;
          end else if (secured && (nonsecure_src || background_debug_mode) &&
                       reg_wdata != `CMD_MASS) begin
            err = 1'b1;
          end else if (secured && background_debug_mode && special_single_chip &&
                       reg_wdata != `CMD_MASS) begin
            err = 1'b1;
          end else if ((reg_wdata == `CMD_PROG || reg_wdata == `CMD_SECT) &&
                       prot_hit) begin
            pv = 1'b1;
          end else if (reg_wdata == `CMD_MASS && !(low_region_protect_disable &&
                       high_region_protect_disable && protection_open_select)) begin
            pv = 1'b1;
          end else begin
            d.buf_e.cmd = reg_wdata;
            d.seq = SEQ_CMD;
          end
        end
      end else if (reg_sel == REG_STATUS) begin
        // clears come first so a same-cycle error still sets the flag
        if (reg_wdata[`STAT_ACC_ERR]) d.acc_err = 1'b0;
        if (reg_wdata[`STAT_PROT_ERR]) d.prot_err = 1'b0;
        if (q.seq == SEQ_WORD) begin
          err = 1'b1;
        end else if (!reg_wdata[`STAT_BUF_EMPTY]) begin
          err = 1'b1;
        end else if (q.seq == SEQ_CMD && !q.acc_err && !q.prot_err) begin
          d.seq = SEQ_QUEUED;
          d.buf_empty = 1'b0;
          d.cmd_done = 1'b0;
        end
      end else begin
        if (reg_sel == REG_CLKDIV) begin
          d.divld = 1'b1;
          d.div = reg_wdata[`DIV_W-1:0];
        end
        if (in_seq) err = 1'b1;
      end
    end

    // an erroneous sequence is thrown away, a queued one is kept
    if (err) begin
      d.acc_err = 1'b1;
      if (in_seq) d.seq = SEQ_EMPTY;
    end
    if (pv) begin
      d.prot_err = 1'b1;
      if (in_seq) d.seq = SEQ_EMPTY;
    end

    // stop entry aborts active and just-launched work; wait mode needs nothing here
    if (stop_mode && !q.stop_seen) begin
      d.stop_seen = 1'b1;
      if (q.act_v || q.seq == SEQ_QUEUED) begin
        d.act_v = 1'b0;
        d.hv_on = 1'b0;
        d.op_start = 1'b0;
        d.seq = SEQ_EMPTY;
        d.cmd_done = 1'b1;
        d.acc_err = 1'b1;
      end
    end else if (!stop_mode && q.stop_seen) begin
      d.stop_seen = 1'b0;
      d.buf_empty = 1'b1;
    end

    // array reads are never checked, only flagged as invalid
    d.rd_invalid = d.act_v || (d.seq == SEQ_QUEUED) || keymode;
    d.prot_wr_en = background_debug_mode;
    d.secure_lvl = d.unsec ? `UNSECURED_CODE : security_byte;
    // level request also serves as the wake source in wait
    d.irq = (d.buf_empty && buffer_empty_irq_enable) ||
            (d.cmd_done && command_complete_irq_enable);
  end

  // synchronous reset drops any running command on the spot
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      q <= '0;
      q.buf_empty <= 1'b1;
      q.cmd_done <= 1'b1;
      q.key_ok <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign op_start = q.op_start;
  assign op = q.act;
  assign hv_on = q.hv_on;
  assign buf_addr = q.buf_e.addr;
  assign access_error_flag = q.acc_err;
  assign protection_violation_flag = q.prot_err;
  assign buffer_empty_flag = q.buf_empty;
  assign command_complete_flag = q.cmd_done;
  assign blank_flag = q.blank;
  assign divider_loaded_flag = q.divld;
  assign read_invalid = q.rd_invalid;
  assign prot_wr_en = q.prot_wr_en;
  assign security_state_field = q.secure_lvl;
  assign irq = q.irq;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_lock;
    q.seq == SEQ_CMD && (q.acc_err || q.prot_err) |=> q.seq != SEQ_QUEUED;
  endproperty
  a_lock: assert property (p_lock) else $error("launch while locked");

  property p_zero_empty;
    reg_wr && reg_sel == REG_STATUS && !reg_wdata[`STAT_BUF_EMPTY] |=> q.acc_err;
  endproperty
  a_zero_empty: assert property (p_zero_empty) else $error("abort missed");

  property p_nodiv;
    arr_wr && !q.divld && !(backdoor_enable && backdoor_access_mode) |=> q.acc_err;
  endproperty
  a_nodiv: assert property (p_nodiv) else $error("write before divider");

  property p_second_word;
    arr_wr && q.seq != SEQ_EMPTY && !(backdoor_enable && backdoor_access_mode)
      |=> q.acc_err;
  endproperty
  a_second_word: assert property (p_second_word) else $error("second word ok");

  property p_badcmd;
    reg_wr && reg_sel == REG_COMMAND && q.seq == SEQ_WORD && !valid_cmd(reg_wdata)
      |=> q.acc_err && q.seq == SEQ_EMPTY;
  endproperty
  a_badcmd: assert property (p_badcmd) else $error("bad command kept");

  // the first edge after reset shows the reset value, not the enables
  property p_irq;
    $past(rst_b) |-> q.irq == ((q.buf_empty && $past(buffer_empty_irq_enable)) ||
                               (q.cmd_done && $past(command_complete_irq_enable)));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_done;
    q.cmd_done |-> !q.act_v && q.seq != SEQ_QUEUED;
  endproperty
  a_done: assert property (p_done) else $error("complete while busy");

  property p_stop;
    $rose(stop_mode) && q.act_v |=> q.acc_err && q.cmd_done && !q.hv_on && !q.act_v;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not abort");

  property p_launch;
    q.seq == SEQ_QUEUED && !q.act_v && !stop_mode
      |=> q.act_v && q.op_start && q.buf_empty ##1 !q.op_start;
  endproperty
  a_launch: assert property (p_launch) else $error("queue did not move");

  property p_unsec;
    q.unsec |-> q.secure_lvl == `UNSECURED_CODE;
  endproperty
  a_unsec: assert property (p_unsec) else $error("unlock not shown");

  property p_c_prog;
    q.op_start && q.act.cmd == `CMD_PROG;
  endproperty
  c_prog: cover property (p_c_prog);

  property p_c_pipe;
    q.act_v && q.seq == SEQ_QUEUED;
  endproperty
  c_pipe: cover property (p_c_pipe);

  property p_c_unlock;
    $rose(q.unsec);
  endproperty
  c_unlock: cover property (p_c_unlock);
endmodule // flash_command_sequencer

`default_nettype wire

// File: sim/array_model.sv
/*
  stand-in for the array engine: protection map and erased state of the array.
  assumes op and op_start come straight from the sequencer's engine side.
*/
`default_nettype none
`include "flash_seq_params.svh"

module array_model #(
  parameter logic [15:0] PROT_BASE = 16'hC000
) (
  // clock
  input wire logic mclk,
  // sequencer side
  input wire logic op_start,
  input wire flash_seq_pkg::cmd_entry_t op,
  input wire logic [15:0] buf_addr,
  // results
  output logic prot_hit,
  output logic blank_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import flash_seq_pkg::*;

  // starts unknown-to-user as programmed, so a verify before any erase reads not blank
  logic erased_q = 1'b0;

  // the top region stands protected, the rest is open
  assign prot_hit = buf_addr >= PROT_BASE;
  assign blank_in = erased_q;

  always @(posedge mclk) begin
    if (op_start && op.cmd == `CMD_MASS) begin
      erased_q <= 1'b1;
    end else if (op_start && op.cmd == `CMD_PROG) begin
      erased_q <= 1'b0;
    end
  end
endmodule // array_model

`default_nettype wire

// File: sim/tb_flash_command_sequencer.sv
/*
  self-checking bench for the flash command sequencer.
  assumes the sequencer and array_model compile first; divider 0 gives one tick per clock.
*/
`default_nettype none
`include "flash_seq_params.svh"

module tb_flash_command_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_seq_pkg::*;

  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic arr_wr = 1'b0;
  logic arr_byte = 1'b0;
  logic reg_wr = 1'b0;
  logic [15:0] arr_addr = 16'h0000;
  logic [15:0] arr_wdata = 16'h0000;
  reg_sel_t reg_sel = REG_OTHER;
  logic [7:0] reg_wdata = 8'h00;
  logic be_ie = 1'b0, cc_ie = 1'b0, key_en = 1'b0, key_acc = 1'b0;
  logic lo_dis = 1'b0, hi_dis = 1'b0, open_sel = 1'b0, page_hit = 1'b0;
  logic stop_mode = 1'b0, dbg = 1'b0, ssc = 1'b0, nonsec = 1'b0;
  logic [1:0] security_byte = 2'h1;
  logic [3:0][15:0] key_words = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
  logic op_start, hv_on, acc, pv, be, cc, blank, divld, rd_inv, pwe, irq, prot_hit, blank_in;
  logic [15:0] buf_addr;
  logic [1:0] lock_state;
  cmd_entry_t op, last_op;
  int err_count = 0, total_checks = 0, starts = 0, cyc = 0, s0;

  always #20 mclk = ~mclk;

  flash_command_sequencer i_flash_command_sequencer (
    .mclk(mclk), .rst_b(rst_b), .arr_wr(arr_wr), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_byte(arr_byte), .reg_wr(reg_wr), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .buffer_empty_irq_enable(be_ie),
    .command_complete_irq_enable(cc_ie), .backdoor_enable(key_en),
    .backdoor_access_mode(key_acc), .low_region_protect_disable(lo_dis),
    .high_region_protect_disable(hi_dis), .protection_open_select(open_sel),
    .prot_hit(prot_hit), .page_hit(page_hit), .stop_mode(stop_mode),
    .background_debug_mode(dbg), .special_single_chip(ssc), .nonsecure_src(nonsec),
    .security_byte(security_byte), .key_words(key_words), .blank_in(blank_in),
    .op_start(op_start),
    .op(op), .hv_on(hv_on), .buf_addr(buf_addr), .access_error_flag(acc),
    .protection_violation_flag(pv), .buffer_empty_flag(be), .command_complete_flag(cc),
    .blank_flag(blank), .divider_loaded_flag(divld), .read_invalid(rd_inv),
    .prot_wr_en(pwe), .security_state_field(lock_state), .irq(irq)
  );

  array_model i_array_model (
    .mclk(mclk), .op_start(op_start), .op(op), .buf_addr(buf_addr),
    .prot_hit(prot_hit), .blank_in(blank_in)
  );

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (op_start === 1'b1) begin
      starts <= starts + 1;
      last_op <= op;
    end
    // the longest command runs 4000 ticks; the whole run stays far below this
    if (cyc == 40000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // each write leaves one idle cycle so a strobe never rises in the step it fell
  task automatic aw(input logic [15:0] a, input logic [15:0] d, input logic b);
    arr_addr = a;
    arr_wdata = d;
    arr_byte = b;
    arr_wr = 1'b1;
    tick(1);
    arr_wr = 1'b0;
    arr_byte = 1'b0;
    tick(1);
  endtask

  task automatic rw(input reg_sel_t s, input logic [7:0] d);
    reg_sel = s;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask

  // bit 7 kept at one: a zero there would itself raise an access error
  task automatic clr();
    rw(REG_STATUS, 8'hB0);
    chk("errors cleared", 2'b00, {acc, pv});
  endtask

  task automatic run(input logic [15:0] a, input logic [15:0] d, input logic [7:0] c);
    aw(a, d, 1'b0);
    rw(REG_COMMAND, c);
    rw(REG_STATUS, 8'h80);
  endtask

  task automatic waitc();
    int n;
    n = 0;
    tick(1);
    chk("complete after launch", 0, cc);
    while (cc !== 1'b1 && n < 6000) begin
      tick(1);
      n++;
    end
    chk("complete", 1, cc);
  endtask

  task automatic bad(input int k);
    case (k)
      0: aw(16'h4001, 16'h0000, 1'b0);
      1: aw(16'h4000, 16'h0000, 1'b1);
      2: aw(16'h8000, 16'h0000, 1'b0);
      default: begin
        aw(16'h4000, 16'h0000, 1'b0);
        if (k > 5) rw(REG_COMMAND, `CMD_PROG);
        case (k)
          3: aw(16'h4002, 16'h0000, 1'b0);
          4: rw(REG_CONFIG, 8'h00);
          5: rw(REG_COMMAND, 8'h33);
          6: rw(REG_STATUS, 8'h00);
          7: rw(REG_PROTECT, 8'h00);
          default: rw(REG_COMMAND, `CMD_PROG);
        endcase
      end
    endcase
  endtask

  task automatic key_try(input logic m);
    dbg = m;
    ssc = m;
    rw(REG_CLKDIV, 8'h00);
    key_en = 1'b1;
    key_acc = 1'b1;
    tick(2);
    chk("reads invalid", 1, rd_inv);
    chk("debug protect write", m, pwe);
    for (int i = 0; i < 4; i++) aw(16'(16'hFF00 + 2 * i), key_words[i], 1'b0);
    key_acc = 1'b0;
    tick(3);
    chk("security", m ? 2'h1 : 2'h2, lock_state);
    rst_b = 1'b0;
    tick(1);
    rst_b = 1'b1;
    tick(2);
    chk("security after reset", 2'h1, lock_state);
  endtask

  initial begin
    tick(5);
    rst_b = 1'b1;
    tick(1);
    chk("reset flags", 3'b110, {be, cc, divld});
    aw(16'h4000, 16'h1234, 1'b0);
    chk("no divider", 1, acc);
    clr();
    rw(REG_CLKDIV, 8'h00);
    chk("loaded", 1, divld);
    for (int k = 0; k < 9; k++) begin
      bad(k);
      chk("illegal write", 1, acc);
      clr();
    end
    run(16'h4010, 16'hA5C3, `CMD_PROG);
    waitc();
    chk("program op", {`CMD_PROG, 16'h4010, 16'hA5C3}, last_op);
    run(16'h41FE, 16'h0000, `CMD_SECT);
    waitc();
    chk("sector addr", 16'h4000, last_op.addr);
    s0 = starts;
    run(16'h4200, 16'h0000, `CMD_SECT);
    run(16'h4022, 16'h2222, `CMD_PROG);
    chk("queued", 0, be);
    aw(16'h4030, 16'h0000, 1'b0);
    chk("write while full", 1, acc);
    waitc();
    chk("both ran", s0 + 2, starts);
    s0 = starts;
    run(16'h4040, 16'h0000, `CMD_PROG);
    tick(4);
    chk("locked", {s0, 1'b1}, {starts, cc});
    clr();
    // the held command is launched once the flags are clear
    rw(REG_STATUS, 8'h80);
    waitc();
    chk("unlocked", s0 + 1, starts);
    run(16'hC000, 16'h0000, `CMD_PROG);
    chk("protected", 1, pv);
    clr();
    run(16'h4000, 16'h0000, `CMD_MASS);
    chk("mass protected", 1, pv);
    clr();
    nonsec = 1'b1;
    run(16'h4000, 16'h0000, `CMD_PROG);
    chk("secured source", 1, acc);
    nonsec = 1'b0;
    clr();
    lo_dis = 1'b1;
    hi_dis = 1'b1;
    open_sel = 1'b1;
    run(16'h4000, 16'h0000, `CMD_MASS);
    waitc();
    chk("mass ran", `CMD_MASS, last_op.cmd);
    for (int v = 0; v < 2; v++) begin
      if (v == 1) begin
        run(16'h4050, 16'h0F0F, `CMD_PROG);
        waitc();
      end
      run(16'h4000, 16'h0000, `CMD_VERIFY);
      waitc();
      chk("blank", v == 0, blank);
    end
    be_ie = 1'b1;
    tick(2);
    chk("irq empty", 1, irq);
    be_ie = 1'b0;
    cc_ie = 1'b1;
    s0 = starts;
    run(16'h4200, 16'h0000, `CMD_SECT);
    run(16'h4022, 16'h2222, `CMD_PROG);
    chk("irq busy", 4'b0110, {irq, hv_on, rd_inv, be});
    stop_mode = 1'b1;
    tick(2);
    chk("stop abort", 4'b1101, {acc, cc, hv_on, irq});
    stop_mode = 1'b0;
    tick(2);
    chk("stop exit", {1'b1, s0 + 1}, {be, starts});
    cc_ie = 1'b0;
    clr();
    run(16'h4200, 16'h0000, `CMD_SECT);
    tick(2);
    rst_b = 1'b0;
    tick(1);
    rst_b = 1'b1;
    chk("reset abort", 2'b00, {hv_on, divld});
    key_try(1'b0);
    key_try(1'b1);
    conclude();
  end
endmodule // tb_flash_command_sequencer

`default_nettype wire
